// *** logic/sync_sram_port.sv ***
// Operation
// - all synchronous pins are captured in registers on the rising clock edge.
// - address and enables load only while a processor or controller strobe is low.
// - after a load, further burst addresses come from inside, stepped by advance.
// - the burst counter is two bits wide, covering four locations.
// - burst order is interleaved or linear, chosen by a mode input.
// - address, data and write controls are registered, then written self-timed.
// - writes cover any combination of the four byte lanes via lane selects.
// - global write low writes every lane regardless of lane selects.
// - output enable and sleep act asynchronously, bypassing input registers.
// - burst reads deliver 3-1-1-1: first word after three clocks, then one each.
// - a deselecting load releases the data outputs within one clock.
// - the array holds 2M words of 36 bits with per-lane write control.
// - low two address bits seed the burst counter start.
// - with global write high, lane writes happen only while byte write enable is sampled low.
// - output enable is ignored in the first clock of a read after deselect.
// - depth enable high is active high; primary and depth low enables active low.
module sync_sram_port
   import sram_port_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // address and strobes
   input wire logic [ADDR_W-1:0] address_in,
   input wire logic processor_address_strobe_n_in,
   input wire logic controller_address_strobe_n_in,
   input wire logic burst_advance_n_in,
   // chip enables
   input wire logic primary_chip_enable_n_in,
   input wire logic depth_enable_high_in,
   input wire logic depth_enable_low_n_in,
   // write controls
   input wire logic [LANES-1:0] byte_lane_write_select_n_in,
   input wire logic byte_write_enable_n_in,
   input wire logic global_write_n_in,
   // asynchronous and mode inputs
   input wire logic output_enable_n_in,
   input wire logic sleep_request_in,
   input wire logic linear_burst_in,
   // data pins
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_out,
   // write queue status
   output logic write_ready_out
);
   logic [ADDR_W-1:BURST_W] addr_hi, next_addr_hi;
   logic [BURST_W-1:0] burst_start, next_burst_start;
   logic [BURST_W-1:0] burst_count, next_burst_count;
   logic [BURST_W-1:0] burst_offset;
   logic selected, next_selected;
   access_t access, next_access;
   logic [LANES-1:0] lane_mask, next_lane_mask;
   logic [DATA_W-1:0] wr_data, next_wr_data;
   logic oe_mask, next_oe_mask;
   logic [DATA_W-1:0] rd_word;
   logic rd_valid, next_rd_valid;
   logic [DATA_W-1:0] next_data_out;
   logic out_valid, next_out_valid;
   logic sleep_s1, sleep_s2, linear_s1, linear_s2;
   logic load, pins_selected, pins_write, deselect_load;
   logic [ADDR_W-1:0] stage_addr;
   logic wq_out_valid, wq_out_ready;
   logic [WQ_W-1:0] wq_out_data;
   logic [ADDR_W-1:0] drain_addr;
   logic [LANES-1:0] drain_mask;
   logic [DATA_W-1:0] drain_data, drain_bits;
   logic [DATA_W-1:0] mem [0:MEM_WORDS-1];

   // chip enable polarity decode, shared by load and assertions
   function automatic logic enables_active(input logic ce1_n, input logic ce2, input logic ce3_n);
      enables_active = !ce1_n && ce2 && !ce3_n;
   endfunction

   // lane mask decode from write controls
   function automatic logic [LANES-1:0] lanes_of(input logic gw_n, input logic bwe_n,
                                                 input logic [LANES-1:0] bws_n);
      if (!gw_n) begin
         lanes_of = LANES_ALL;
      end else if (!bwe_n) begin
         lanes_of = ~bws_n;
      end else begin
         lanes_of = LANES_NONE;
      end
   endfunction

   // strap and sleep synchronisers
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sleep_s1 <= 1'b0;
         sleep_s2 <= 1'b0;
         linear_s1 <= 1'b0;
         linear_s2 <= 1'b0;
      end else begin
         sleep_s1 <= sleep_request_in;
         sleep_s2 <= sleep_s1;
         linear_s1 <= linear_burst_in;
         linear_s2 <= linear_s1;
      end
   end

   // processor strobe counts only with primary enable low
   assign load = (!processor_address_strobe_n_in && !primary_chip_enable_n_in)
                 || !controller_address_strobe_n_in;
   assign pins_selected = enables_active(primary_chip_enable_n_in, depth_enable_high_in,
                                         depth_enable_low_n_in) && !sleep_s2;
   assign pins_write = (lanes_of(global_write_n_in, byte_write_enable_n_in,
                                 byte_lane_write_select_n_in) != LANES_NONE);
   assign deselect_load = load && !pins_selected;

   // input capture and burst control
   always_comb begin
      next_addr_hi = addr_hi;
      next_burst_start = burst_start;
      next_burst_count = burst_count;
      next_selected = selected && !sleep_s2;
      next_access = ACC_NONE;
      next_oe_mask = 1'b0;
      next_lane_mask = lanes_of(global_write_n_in, byte_write_enable_n_in,
                                byte_lane_write_select_n_in);
      next_wr_data = data_in;
      if (load) begin
         next_addr_hi = address_in[ADDR_W-1:BURST_W];
         next_burst_start = address_in[BURST_W-1:0];
         next_burst_count = COUNT_RESET;
         next_selected = pins_selected;
         if (pins_selected) begin
            // first cycle after a processor strobe is always a read
            if (processor_address_strobe_n_in && pins_write) begin
               next_access = ACC_WRITE;
            end else begin
               next_access = ACC_READ;
               next_oe_mask = !selected;
            end
         end
      end else if (next_selected) begin
         if (!burst_advance_n_in) begin
            next_burst_count = BURST_W'(burst_count + 1'b1);
         end
         if (pins_write) begin
            next_access = ACC_WRITE;
         end else if (!burst_advance_n_in) begin
            next_access = ACC_READ;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         addr_hi <= ADDR_RESET[ADDR_W-1:BURST_W];
         burst_start <= COUNT_RESET;
         burst_count <= COUNT_RESET;
         selected <= 1'b0;
         access <= ACC_NONE;
         lane_mask <= LANES_NONE;
         wr_data <= DATA_RESET;
         oe_mask <= 1'b0;
      end else begin
         addr_hi <= next_addr_hi;
         burst_start <= next_burst_start;
         burst_count <= next_burst_count;
         selected <= next_selected;
         access <= next_access;
         lane_mask <= next_lane_mask;
         wr_data <= next_wr_data;
         oe_mask <= next_oe_mask;
      end
   end

   burst_sequencer u_burst (
      .start_in(burst_start),
      .count_in(burst_count),
      .linear_in(linear_s2),
      .offset_out(burst_offset)
   );

   assign stage_addr = {addr_hi, burst_offset};

   // registered writes wait here until the array is free
   write_queue #(
      .WIDTH(WQ_W),
      .DEPTH(WQ_DEPTH)
   ) u_wq (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .in_valid_in(access == ACC_WRITE),
      .in_ready_out(write_ready_out),
      .in_data_in({stage_addr, lane_mask, wr_data}),
      .out_valid_out(wq_out_valid),
      .out_ready_in(wq_out_ready),
      .out_data_out(wq_out_data)
   );

   // reads own the array; queued writes drain on other cycles
   assign wq_out_ready = (access != ACC_READ);
   assign drain_addr = wq_out_data[WQ_W-1 -: ADDR_W];
   assign drain_mask = wq_out_data[DATA_W +: LANES];
   assign drain_data = wq_out_data[DATA_W-1:0];

   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         assign drain_bits[lane*LANE_W +: LANE_W] = {LANE_W{drain_mask[lane]}};
      end
   endgenerate

   // array, word addressed with lane writes
   always_ff @(posedge clk_sys_in) begin
      if (wq_out_valid && wq_out_ready) begin
         mem[drain_addr] <= (mem[drain_addr] & ~drain_bits) | (drain_data & drain_bits);
      end
      if (access == ACC_READ) begin
         rd_word <= mem[stage_addr];
      end
   end

   // output pipeline
   always_comb begin
      next_rd_valid = 1'b0;
      next_data_out = data_out;
      next_out_valid = out_valid;
      case (access)
         ACC_READ: next_rd_valid = 1'b1;
         ACC_WRITE: next_rd_valid = 1'b0;
         ACC_NONE: next_rd_valid = 1'b0;
         default: next_rd_valid = 1'b0;
      endcase
      if (rd_valid) begin
         next_data_out = rd_word;
         next_out_valid = 1'b1;
      end
      if (deselect_load || sleep_s2 || access == ACC_WRITE) begin
         next_out_valid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_valid <= 1'b0;
         data_out <= DATA_RESET;
         out_valid <= 1'b0;
      end else begin
         rd_valid <= next_rd_valid;
         data_out <= next_data_out;
         out_valid <= next_out_valid;
      end
   end

   // pin drive gated asynchronously by output enable and sleep
   assign data_oe_out = out_valid && selected && !oe_mask
                        && !output_enable_n_in && !sleep_request_in;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   addr_load_a: assert property (
      load |=> addr_hi == $past(address_in[ADDR_W-1:BURST_W]))
      else $error("address not loaded on strobe");

   no_strobe_hold_a: assert property (
      !load |=> $stable(addr_hi) && $stable(burst_start))
      else $error("address changed without strobe");

   burst_seed_a: assert property (
      load |=> burst_start == $past(address_in[BURST_W-1:0]) && burst_count == COUNT_RESET)
      else $error("burst start not seeded from low address");

   burst_step_a: assert property (
      !load && next_selected && !burst_advance_n_in |=> burst_count == BURST_W'($past(burst_count) + 1'b1))
      else $error("burst counter did not advance");

   burst_order_a: assert property (
      linear_s2 |-> burst_offset == BURST_W'(burst_start + burst_count))
      else $error("linear burst order wrong");

   global_lanes_a: assert property (
      !global_write_n_in |=> lane_mask == LANES_ALL)
      else $error("global write did not select every lane");

   lane_gate_a: assert property (
      global_write_n_in && byte_write_enable_n_in |=> lane_mask == LANES_NONE && access != ACC_WRITE)
      else $error("lane write without byte write enable");

   read_latency_a: assert property (
      (access == ACC_READ) ##1 (!deselect_load && !sleep_s2 && access != ACC_WRITE)
      |=> out_valid && data_out == $past(rd_word))
      else $error("read word not presented on time");

   deselect_release_a: assert property (
      deselect_load |=> !data_oe_out && !out_valid)
      else $error("outputs not released after deselect");

   oe_async_a: assert property (
      output_enable_n_in || sleep_request_in |-> !data_oe_out)
      else $error("pins driven with output enable high");

   first_read_mask_a: assert property (
      load && pins_selected && !selected && next_access == ACC_READ |=> !data_oe_out)
      else $error("output enable honoured in first read clock");

   write_queued_a: assert property (
      access == ACC_WRITE && write_ready_out |=> wq_out_valid)
      else $error("registered write not queued");

   enable_polarity_a: assert property (
      load && (primary_chip_enable_n_in || !depth_enable_high_in || depth_enable_low_n_in)
      |=> !selected)
      else $error("wrong chip enable polarity");

   interleave_order_a: assert property (
      !linear_s2 |-> burst_offset == (burst_start ^ burst_count))
      else $error("interleaved burst order wrong");

   burst_hold_a: assert property (
      !load && burst_advance_n_in |=> $stable(burst_count))
      else $error("burst counter moved without advance");

   deselect_hold_a: assert property (
      !load && !selected |=> !selected)
      else $error("part selected without a load");

   select_polarity_a: assert property (
      load && enables_active(primary_chip_enable_n_in, depth_enable_high_in, depth_enable_low_n_in) && !sleep_s2
      |=> selected)
      else $error("enables active but part not selected");

   write_lanes_a: assert property (
      access == ACC_WRITE |-> lane_mask != LANES_NONE)
      else $error("registered write with no lanes");

   byte_lanes_a: assert property (
      global_write_n_in && !byte_write_enable_n_in |=> lane_mask == ~$past(byte_lane_write_select_n_in))
      else $error("lane mask does not follow lane selects");

   read_stage_a: assert property (
      access == ACC_READ |=> rd_valid)
      else $error("array read not staged");

   oe_drive_a: assert property (
      data_oe_out |-> out_valid && selected)
      else $error("pins driven while not selected and reading");

   write_release_a: assert property (
      access == ACC_WRITE |=> !out_valid)
      else $error("read data still valid after write cycle");

   sleep_deselect_a: assert property (
      sleep_s2 |=> !selected && !out_valid)
      else $error("synced sleep did not deselect");
endmodule

// *** logic/sram_port_pkg.sv ***
package sram_port_pkg;
   // array geometry
   localparam int ADDR_W = 21;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BURST_W = 2;
   localparam int MEM_WORDS = 2097152;
   // byte lane masks
   localparam logic [3:0] LANES_ALL = 4'hF;
   localparam logic [3:0] LANES_NONE = 4'h0;
   // pending write queue
   localparam int WQ_DEPTH = 16;
   localparam int WQ_W = ADDR_W + LANES + DATA_W;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
   localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
   // stage access kind
   typedef enum logic [1:0] {
      ACC_NONE = 2'b00,
      ACC_READ = 2'b01,
      ACC_WRITE = 2'b10
   } access_t;
endpackage

// *** logic/burst_sequencer.sv ***
module burst_sequencer
   import sram_port_pkg::*;
(
   // burst state
   input wire logic [BURST_W-1:0] start_in,
   input wire logic [BURST_W-1:0] count_in,
   input wire logic linear_in,
   // word offset
   output logic [BURST_W-1:0] offset_out
);
   // interleaved flips start bits, linear wraps the sum in two bits
   always_comb begin
      if (linear_in) begin
         offset_out = BURST_W'(start_in + count_in);
      end else begin
         offset_out = start_in ^ count_in;
      end
   end
endmodule

// *** logic/write_queue.sv ***
module write_queue #(
   parameter int WIDTH = 61,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] slots [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PTR_W:0] fill, next_fill;
   logic push, pop;

   assign in_ready_out = (fill != (PTR_W+1)'(DEPTH));
   assign out_valid_out = (fill != '0);
   assign out_data_out = slots[rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      next_wr_ptr = push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
      next_fill = fill;
      if (push && !pop) begin
         next_fill = (PTR_W+1)'(fill + 1'b1);
      end else if (pop && !push) begin
         next_fill = (PTR_W+1)'(fill - 1'b1);
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill <= next_fill;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         slots[wr_ptr] <= in_data_in;
      end
   end
endmodule

// *** tb/sram_host_model.sv ***
module sram_host_model
   import sram_port_pkg::*;
(
   // clock and read side
   input wire logic clk_sys_in,
   input wire logic [DATA_W-1:0] rdata_in,
   input wire logic rdoe_in,
   // address, strobes and enables {primary_n, high, low_n}
   output logic [ADDR_W-1:0] addr_out,
   output logic pstb_n_out,
   output logic cstb_n_out,
   output logic step_n_out,
   output logic [2:0] en_out,
   // write controls and data
   output logic [LANES-1:0] lane_n_out,
   output logic lane_en_n_out,
   output logic all_wr_n_out,
   output logic [DATA_W-1:0] wdata_out,
   // static and asynchronous pins
   output logic oe_n_out,
   output logic sleep_out,
   output logic lin_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      addr_out = ADDR_RESET;
      pstb_n_out = 1'b1;
      cstb_n_out = 1'b1;
      step_n_out = 1'b1;
      en_out = 3'h6;
      lane_n_out = 4'hF;
      lane_en_n_out = 1'b1;
      all_wr_n_out = 1'b1;
      wdata_out = DATA_RESET;
      oe_n_out = 1'b0;
      sleep_out = 1'b0;
      lin_out = 1'b0;
   end

   // released data bus shows the inverse of its last value
   task automatic idle();
      pstb_n_out <= 1'b1;
      cstb_n_out <= 1'b1;
      lane_en_n_out <= 1'b1;
      all_wr_n_out <= 1'b1;
      wdata_out <= ~wdata_out;
   endtask

   task automatic load(input logic [ADDR_W-1:0] a, input logic proc, input logic [2:0] en);
      addr_out <= a;
      pstb_n_out <= !proc;
      cstb_n_out <= proc;
      en_out <= en;
   endtask

   task automatic write(input logic [ADDR_W-1:0] a, input logic [3:0] ln, input logic be, input logic gw,
                        input logic [DATA_W-1:0] d);
      @(posedge clk_sys_in);
      load(a, 1'b0, 3'h2);
      lane_n_out <= ln;
      lane_en_n_out <= be;
      all_wr_n_out <= gw;
      wdata_out <= d;
      @(posedge clk_sys_in);
      idle();
   endtask

   // word k is taken at the fourth edge after the load plus k
   task automatic read(input logic [ADDR_W-1:0] a, input int n, output logic [DATA_W-1:0] w [4],
                       output logic oe);
      @(posedge clk_sys_in);
      load(a, 1'b1, 3'h2);
      for (int i = 0; i < n + 3; i++) begin
         @(posedge clk_sys_in);
         if (i >= 3) w[i-3] = rdata_in;
         if (i == 3) oe = rdoe_in;
         if (i == 0) idle();
         step_n_out <= (i >= n - 1);
      end
   endtask

   task automatic pins(input logic oe_n, input logic slp, input logic lin);
      oe_n_out <= oe_n;
      sleep_out <= slp;
      lin_out <= lin;
   endtask
endmodule

// *** tb/tb_sync_sram_port.sv ***
module tb_sync_sram_port;
   timeunit 1ns;
   timeprecision 100ps;
   import sram_port_pkg::*;

   typedef struct {
      logic [ADDR_W-1:0] a;
      logic [LANES-1:0] ln;
      logic be;
      logic gw;
      logic [DATA_W-1:0] d;
   } row_t;

   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic pstb_n, cstb_n, step_n, be_n, gw_n, oe_n, slp, lin, data_oe_out, write_ready_out, oe_seen;
   logic [2:0] en;
   logic [LANES-1:0] ln_n;
   logic [DATA_W-1:0] wdata, data_out;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]] = '{default: 'x};
   logic [DATA_W-1:0] w [4];
   logic [3:0] desel [4] = '{4'h6, 4'h0, 4'h3, 4'hE};
   int mismatches = 0;
   int n_checks = 0;
   row_t rows [6] = '{
      '{21'h000010, 4'hF, 1'b1, 1'b0, 36'h123456789},
      '{21'h000010, 4'hE, 1'b0, 1'b1, 36'hFFFFFFFFF},
      '{21'h000010, 4'hC, 1'b0, 1'b1, 36'h000000000},
      '{21'h000010, 4'h0, 1'b1, 1'b1, 36'h0AAAAAAAA},
      '{21'h1FFFFF, 4'h0, 1'b0, 1'b1, 36'hABCDEF012},
      '{21'h1FFFFF, 4'h7, 1'b1, 1'b0, 36'h5A5A5A5A5}
   };

   always #5 clk_sys_in = ~clk_sys_in;

   sync_sram_port i_dut (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .address_in(addr),
      .processor_address_strobe_n_in(pstb_n),
      .controller_address_strobe_n_in(cstb_n),
      .burst_advance_n_in(step_n),
      .primary_chip_enable_n_in(en[2]),
      .depth_enable_high_in(en[1]),
      .depth_enable_low_n_in(en[0]),
      .byte_lane_write_select_n_in(ln_n),
      .byte_write_enable_n_in(be_n),
      .global_write_n_in(gw_n),
      .output_enable_n_in(oe_n),
      .sleep_request_in(slp),
      .linear_burst_in(lin),
      .data_in(wdata),
      .data_out(data_out),
      .data_oe_out(data_oe_out),
      .write_ready_out(write_ready_out)
   );

   sram_host_model i_host (
      .clk_sys_in(clk_sys_in),
      .rdata_in(data_out),
      .rdoe_in(data_oe_out),
      .addr_out(addr),
      .pstb_n_out(pstb_n),
      .cstb_n_out(cstb_n),
      .step_n_out(step_n),
      .en_out(en),
      .lane_n_out(ln_n),
      .lane_en_n_out(be_n),
      .all_wr_n_out(gw_n),
      .wdata_out(wdata),
      .oe_n_out(oe_n),
      .sleep_out(slp),
      .lin_out(lin)
   );

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input row_t r);
      for (int k = 0; k < LANES; k++) begin
         if (!r.gw || (!r.be && !r.ln[k])) old[k*LANE_W +: LANE_W] = r.d[k*LANE_W +: LANE_W];
      end
      return old;
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      mismatches++;
      final_report();
   end

   initial begin
      repeat (19) @(posedge clk_sys_in);
      check(data_oe_out, 1'b0);
      check(write_ready_out, 1'b1);
      check(data_out, DATA_RESET);
      @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      // ordinary writes, each read back
      foreach (rows[q]) begin
         i_host.write(rows[q].a, rows[q].ln, rows[q].be, rows[q].gw, rows[q].d);
         mem[rows[q].a] = merge(mem[rows[q].a], rows[q]);
         repeat (4) @(posedge clk_sys_in);
         i_host.read(rows[q].a, 1, w, oe_seen);
         check(w[0], mem[rows[q].a]);
         check(oe_seen, 1'b1);
      end
      // bursts from every start offset in both orders
      for (int k = 0; k < 4; k++) begin
         i_host.write(21'h000040 | ADDR_W'(k), 4'hF, 1'b1, 1'b0, 36'h100 + DATA_W'(k));
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys_in);
         i_host.pins(1'b0, 1'b0, m[0]);
         repeat (4) @(posedge clk_sys_in);
         for (int s = 0; s < 4; s++) begin
            i_host.read(21'h000040 | ADDR_W'(s), 4, w, oe_seen);
            for (int i = 0; i < 4; i++) begin
               check(w[i], 36'h100 + DATA_W'(m ? (s + i) % 4 : s ^ i));
            end
         end
      end
      // deselect by each enable, then a processor strobe that is ignored
      foreach (desel[j]) begin
         i_host.read(21'h000040, 1, w, oe_seen);
         check(data_oe_out, 1'b1);
         i_host.load(21'h000041, desel[j][3], desel[j][2:0]);
         @(posedge clk_sys_in);
         i_host.idle();
         #1 check(data_oe_out, desel[j][3]);
         @(posedge clk_sys_in);
      end
      // output enable and sleep act between edges
      i_host.read(21'h000040, 1, w, oe_seen);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_sys_in);
         #3 i_host.pins(p == 0, p == 1, 1'b1);
         #1 check(data_oe_out, 1'b0);
         i_host.pins(1'b0, 1'b0, 1'b1);
         #1 check(data_oe_out, 1'b1);
      end
      // sleep held over several edges deselects until the next load
      @(posedge clk_sys_in);
      i_host.pins(1'b0, 1'b1, 1'b1);
      repeat (4) @(posedge clk_sys_in);
      check(data_oe_out, 1'b0);
      i_host.pins(1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk_sys_in);
      check(data_oe_out, 1'b0);
      i_host.read(21'h000040, 1, w, oe_seen);
      check(w[0], 36'h100);
      check(oe_seen, 1'b1);
      final_report();
   end
endmodule
